//--- src/tzc_pkg.sv
// Package for the timer zero counter: offsets, fields, codes
package tzc_pkg;
    // Register offsets
    localparam logic [11:0] ADDR_COUNT_LOW    = 12'h59C;
    localparam logic [11:0] ADDR_COUNT_HIGH   = 12'h59D;
    localparam logic [11:0] ADDR_CONTROL_ZERO = 12'h59E;
    localparam logic [11:0] ADDR_CONTROL_ONE  = 12'h59F;
    localparam logic [11:0] ADDR_IRQ_STATUS   = 12'h5A0;
    localparam logic [11:0] ADDR_IRQ_MASK     = 12'h5A1;
    // Reset values
    localparam logic [7:0]  RESET_BYTE        = 8'h00;
    // Control zero fields
    localparam int          CZ_ENABLE_BIT     = 7;
    localparam int          CZ_UNUSED_BIT     = 6;
    localparam int          CZ_OUT_BIT        = 5;
    localparam int          CZ_WIDE_BIT       = 4;
    localparam int          DIV_FIELD_MSB     = 3;
    // Control one fields
    localparam int          CO_CS_MSB         = 7;
    localparam int          CO_CS_LSB         = 5;
    localparam int          CO_ASYNC_BIT      = 4;
    // Clock source codes
    typedef enum logic [2:0] {
        TZC_SRC_PIN_TRUE  = 3'h0,
        TZC_SRC_PIN_INV   = 3'h1,
        TZC_SRC_INSTR     = 3'h2,
        TZC_SRC_HFOSC     = 3'h3,
        TZC_SRC_LFOSC     = 3'h4,
        TZC_SRC_MFOSC     = 3'h5,
        TZC_SRC_SECONDARY_OSCILLATOR      = 3'h6,
        TZC_SRC_LOGIC     = 3'h7
    } tzc_src_e;
    // Instruction clock divides the core clock by four
    localparam logic [1:0]  INSTR_DIV_LAST    = 2'h3;
    localparam logic [14:0] PRE_ONE           = 15'h0001;
    localparam logic [7:0]  BYTE_ONES         = 8'hFF;
endpackage

//--- src/tzc_edge_sync.sv
// Edge detector for one clock source with two-flop synchroniser and optional instruction-tick alignment
`timescale 1ns/1ps
module tzc_edge_sync
    import tzc_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk_in,
    input  wire logic rst_in,
    // Source and control
    input  wire logic src_in,
    input  wire logic unsync_in,
    input  wire logic instr_tick_in,
    // Rising edge event
    output logic      rise_out
);
    logic meta_q;
    logic sync_q;
    logic last_q;
    logic held_q;
    logic pend_q;
    logic rise_d;

    // Two flops before the source is used
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= src_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // Synchronous mode releases an edge only on an instruction tick
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            pend_q <= 1'b0;
            held_q <= 1'b0;
        end else begin
            held_q <= rise_d;
            if (instr_tick_in) begin
                pend_q <= 1'b0;
            end else if (sync_q && !last_q) begin
                pend_q <= 1'b1;
            end
        end
    end

    always_comb begin
        if (unsync_in) begin
            rise_d = sync_q && !last_q;
        end else begin
            rise_d = instr_tick_in && (pend_q || (sync_q && !last_q));
        end
    end

    assign rise_out = held_q;
endmodule

//--- src/tzc_timer.sv
// Timer zero counter: 8/16-bit timer with prescaler, postscaler and register port
//
// Notes on behaviour
// RULE1: The enable bit lets the timer count when set and stops it when clear.
// RULE2: The width select bit picks 16-bit operation at one and 8-bit at zero.
// RULE3: In 8-bit mode the low count register is the full 8-bit counter.
// RULE4: In 8-bit mode the high register is the period and the counter restarts at zero on it.
// RULE5: In 16-bit mode low and high registers are the low and high bytes of the count.
// RULE6: Control zero bits 3 to 0 divide the output by the field plus one.
// RULE7: Control one bits 3 to 0 divide the input clock by two to the field.
// RULE8: Control one bits 7 to 5 select the counting clock source.
// RULE9: Source code one counts the inverted pin input and code zero the true one.
// RULE10: The unsync bit skips synchronising to the instruction clock; clear, it syncs.
// RULE11: Control zero bit 5 reads the output level and ignores writes.
// RULE12: In 8-bit mode a buffered period is compared and reloaded on each match.
// RULE13: In 16-bit mode a low read latches the high byte and a low write loads it.
// RULE14: Writes to low count or either control register and reset clear both scalers.
// RULE15: Output toggles and the flag sets every postscale plus one matches or rollovers.
// RULE16: Control zero bit 6 reads zero and ignores writes.
`timescale 1ns/1ps
module tzc_timer
    import tzc_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    // Register port
    input  wire logic [11:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [7:0]  rdata_out,
    // Clock sources
    input  wire logic        ext_pin_in,
    input  wire logic        logic_cell_output_in,
    input  wire logic        secondary_oscillator_in,
    input  wire logic        medium_internal_oscillator_in,
    input  wire logic        low_freq_oscillator_in,
    input  wire logic        high_freq_oscillator_in,
    // Results
    output logic             timer_toggle_output_out,
    output logic             irq_out
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0]  count_low_q;
    logic [7:0]  count_high_q;
    logic [7:0]  high_live_q;
    logic [7:0]  period_buf_q;
    logic        module_enable_q;
    logic        wide_mode_select_q;
    logic [3:0]  post_divider_select_q;
    logic [2:0]  count_clock_select_q;
    logic        input_unsync_enable_q;
    logic [3:0]  pre_divider_select_q;
    logic        out_q;
    logic        irq_status_q;
    logic        irq_mask_q;
    logic        irq_q;
    logic [7:0]  rdata_q;
    logic [1:0]  instr_cnt_q;
    logic        instr_clk_q;
    logic        instr_tick;
    logic [14:0] pre_cnt_q;
    logic [3:0]  post_cnt_q;
    logic        src_sel;
    logic        src_rise;
    logic        pre_tick;
    logic        match;
    logic        wrap;
    logic        event_hit;
    logic        scaler_clr;
    logic        wr_low;
    logic        rd_low;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] base);
        hit = (a == base);
    endfunction

    assign wr_low     = wr_in && hit(addr_in, ADDR_COUNT_LOW);
    assign rd_low     = rd_in && hit(addr_in, ADDR_COUNT_LOW);
    assign scaler_clr = wr_low || (wr_in && (hit(addr_in, ADDR_CONTROL_ZERO)
                        || hit(addr_in, ADDR_CONTROL_ONE)));  // RULE14

    ////////////////////////////////////////////////////////////////////////////
    // Instruction clock: core clock divided by four
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            instr_cnt_q <= 2'h0;
            instr_clk_q <= 1'b0;
        end else begin
            instr_cnt_q <= instr_cnt_q + 2'h1;
            instr_clk_q <= (instr_cnt_q < 2'h2);
        end
    end
    assign instr_tick = (instr_cnt_q == INSTR_DIV_LAST);

    ////////////////////////////////////////////////////////////////////////////
    // Clock source select
    always_comb begin
        unique case (tzc_src_e'(count_clock_select_q))  // RULE8
            TZC_SRC_PIN_TRUE: src_sel = ext_pin_in;  // RULE9
            TZC_SRC_PIN_INV:  src_sel = !ext_pin_in;  // RULE9
            TZC_SRC_INSTR:    src_sel = instr_clk_q;
            TZC_SRC_HFOSC:    src_sel = high_freq_oscillator_in;
            TZC_SRC_LFOSC:    src_sel = low_freq_oscillator_in;
            TZC_SRC_MFOSC:    src_sel = medium_internal_oscillator_in;
            TZC_SRC_SECONDARY_OSCILLATOR:     src_sel = secondary_oscillator_in;
            TZC_SRC_LOGIC:    src_sel = logic_cell_output_in;
        endcase
    end

    tzc_edge_sync u_edge (
        .core_clk_in   (core_clk_in),
        .rst_in        (rst_in),
        .src_in        (src_sel),
        .unsync_in     (input_unsync_enable_q),  // RULE10
        .instr_tick_in (instr_tick),
        .rise_out      (src_rise)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler: divide by two to the field
    assign pre_tick = module_enable_q && src_rise
                      && ((pre_cnt_q + PRE_ONE) == (PRE_ONE << pre_divider_select_q));  // RULE7

    always_ff @(posedge core_clk_in) begin
        if (rst_in || scaler_clr) begin
            pre_cnt_q <= 15'h0;  // RULE14
        end else if (module_enable_q && src_rise) begin
            pre_cnt_q <= pre_tick ? 15'h0 : pre_cnt_q + PRE_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter
    assign match = !wide_mode_select_q && (count_low_q == period_buf_q);  // RULE12
    assign wrap  = wide_mode_select_q && (count_low_q == BYTE_ONES)
                   && (high_live_q == BYTE_ONES);
    assign event_hit = pre_tick && (match || wrap);

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            count_low_q  <= RESET_BYTE;
            high_live_q  <= RESET_BYTE;
            period_buf_q <= RESET_BYTE;
        end else if (wr_low) begin
            count_low_q <= wdata_in;
            if (wide_mode_select_q) begin
                high_live_q <= count_high_q;  // RULE13
            end
        end else if (pre_tick) begin  // RULE1
            if (!wide_mode_select_q) begin  // RULE2
                if (match) begin
                    count_low_q  <= RESET_BYTE;  // RULE4
                    period_buf_q <= count_high_q;  // RULE12
                end else begin
                    count_low_q <= count_low_q + 8'h01;  // RULE3
                end
            end else begin
                count_low_q <= count_low_q + 8'h01;  // RULE5
                if (count_low_q == BYTE_ONES) begin
                    high_live_q <= high_live_q + 8'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Postscaler, output and interrupt
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            post_cnt_q <= 4'h0;
            out_q      <= 1'b0;
        end else if (scaler_clr) begin
            post_cnt_q <= 4'h0;  // RULE14
        end else if (event_hit) begin
            if (post_cnt_q >= post_divider_select_q) begin
                post_cnt_q <= 4'h0;
                out_q      <= !out_q;  // RULE15
            end else begin
                post_cnt_q <= post_cnt_q + 4'h1;  // RULE6
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            irq_status_q <= 1'b0;
        end else if (event_hit && !scaler_clr && post_cnt_q >= post_divider_select_q) begin
            irq_status_q <= 1'b1;  // RULE15
        end else if (wr_in && hit(addr_in, ADDR_IRQ_STATUS) && wdata_in[0]) begin
            irq_status_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_status_q && irq_mask_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            count_high_q          <= RESET_BYTE;
            module_enable_q       <= 1'b0;
            wide_mode_select_q    <= 1'b0;
            post_divider_select_q <= 4'h0;
            count_clock_select_q  <= 3'h0;
            input_unsync_enable_q <= 1'b0;
            pre_divider_select_q  <= 4'h0;
            irq_mask_q            <= 1'b0;
        end else if (wr_in) begin
            if (hit(addr_in, ADDR_COUNT_HIGH)) begin
                count_high_q <= wdata_in;
            end
            if (hit(addr_in, ADDR_CONTROL_ZERO)) begin
                module_enable_q       <= wdata_in[CZ_ENABLE_BIT];  // RULE1
                wide_mode_select_q    <= wdata_in[CZ_WIDE_BIT];  // RULE2
                post_divider_select_q <= wdata_in[DIV_FIELD_MSB:0];  // RULE6
            end
            if (hit(addr_in, ADDR_CONTROL_ONE)) begin
                count_clock_select_q  <= wdata_in[CO_CS_MSB:CO_CS_LSB];
                input_unsync_enable_q <= wdata_in[CO_ASYNC_BIT];
                pre_divider_select_q  <= wdata_in[DIV_FIELD_MSB:0];
            end
            if (hit(addr_in, ADDR_IRQ_MASK)) begin
                irq_mask_q <= wdata_in[0];
            end
        end else if (rd_low && wide_mode_select_q) begin
            count_high_q <= high_live_q;  // RULE13
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register reads, data one cycle later
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rdata_q <= RESET_BYTE;
        end else if (rd_in) begin
            rdata_q <= RESET_BYTE;
            if (hit(addr_in, ADDR_COUNT_LOW)) begin
                rdata_q <= count_low_q;
            end
            if (hit(addr_in, ADDR_COUNT_HIGH)) begin
                rdata_q <= wide_mode_select_q ? high_live_q : count_high_q;
            end
            if (hit(addr_in, ADDR_CONTROL_ZERO)) begin
                rdata_q[CZ_ENABLE_BIT]     <= module_enable_q;
                rdata_q[CZ_UNUSED_BIT]     <= 1'b0;  // RULE16
                rdata_q[CZ_OUT_BIT]        <= out_q;  // RULE11
                rdata_q[CZ_WIDE_BIT]       <= wide_mode_select_q;
                rdata_q[DIV_FIELD_MSB:0]   <= post_divider_select_q;
            end
            if (hit(addr_in, ADDR_CONTROL_ONE)) begin
                rdata_q <= {count_clock_select_q, input_unsync_enable_q,
                            pre_divider_select_q};
            end
            if (hit(addr_in, ADDR_IRQ_STATUS)) begin
                rdata_q[0] <= irq_status_q;
            end
            if (hit(addr_in, ADDR_IRQ_MASK)) begin
                rdata_q[0] <= irq_mask_q;
            end
        end else begin
            rdata_q <= RESET_BYTE;
        end
    end

    assign rdata_out               = rdata_q;
    assign timer_toggle_output_out = out_q;
    assign irq_out                 = irq_q;
endmodule

//--- dv/tzc_timer_properties.sv
// Port checker for the timer zero counter
`timescale 1ns/1ps
module tzc_timer_properties
    import tzc_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    // Register port
    input  wire logic [11:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    input  wire logic [7:0]  rdata_out,
    // Results
    input  wire logic        timer_toggle_output_out,
    input  wire logic        irq_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////////////////////
    // Cycles since the last irq cause
    logic [2:0] since_q;
    logic       tog_q;
    always_ff @(posedge core_clk_in) begin
        tog_q <= timer_toggle_output_out;
        if (rst_in) begin
            since_q <= 3'h7;
        end else if ((wr_in && addr_in == ADDR_IRQ_MASK) || tog_q != timer_toggle_output_out) begin
            since_q <= 3'h0;
        end else if (since_q != 3'h7) begin
            since_q <= since_q + 3'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////////
    sequence s_rd_cz; rd_in && addr_in == ADDR_CONTROL_ZERO; endsequence
    sequence s_rd_co; rd_in && addr_in == ADDR_CONTROL_ONE; endsequence
    property p_bit6; s_rd_cz |=> rdata_out[6] == 1'b0; endproperty
    a_bit6: assert property (p_bit6) else $error("unused bit read nonzero");
    property p_outcopy;
        s_rd_cz |=> rdata_out[5] == $past(timer_toggle_output_out)
            || rdata_out[5] == timer_toggle_output_out;
    endproperty
    a_outcopy: assert property (p_outcopy) else $error("output copy bit wrong");
    property p_cz_rb;
        logic [7:0] v;
        (wr_in && addr_in == ADDR_CONTROL_ZERO, v = wdata_in) ##2 s_rd_cz
            |=> {rdata_out[7], rdata_out[4:0]} == {v[7], v[4:0]};
    endproperty
    a_cz_rb: assert property (p_cz_rb) else $error("control zero readback");
    property p_co_rb;
        logic [7:0] v;
        (wr_in && addr_in == ADDR_CONTROL_ONE, v = wdata_in) ##2 s_rd_co |=> rdata_out == v;
    endproperty
    a_co_rb: assert property (p_co_rb) else $error("control one readback");
    property p_dis;
        wr_in && addr_in == ADDR_CONTROL_ZERO && !wdata_in[7]
            |=> ##2 $stable(timer_toggle_output_out) [*8];
    endproperty
    a_dis: assert property (p_dis) else $error("output moved while disabled");
    property p_gap; $changed(timer_toggle_output_out) |=> $stable(timer_toggle_output_out); endproperty
    a_gap: assert property (p_gap) else $error("output toggled twice in a row");
    property p_mask_off; wr_in && addr_in == ADDR_IRQ_MASK && !wdata_in[0] |-> ##2 !irq_out; endproperty
    a_mask_off: assert property (p_mask_off) else $error("masked irq high");
    property p_irq_cause; $rose(irq_out) |-> since_q < 3'h5; endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
endmodule
bind tzc_timer tzc_timer_properties u_props (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .timer_toggle_output_out(timer_toggle_output_out),
    .irq_out(irq_out));

//--- dv/tb_top.sv
// Testbench for the timer zero counter
`timescale 1ns/1ps
module tb_top
    import tzc_pkg::*;
;
    logic        core_clk_in = 1'b0;
    logic        rst_in      = 1'b1;
    logic        wr_s        = 1'b0;
    logic        rd_s        = 1'b0;
    logic        pin_s       = 1'b0;
    logic [11:0] addr_s      = 12'h000;
    logic [7:0]  wdata_s     = 8'h00;
    logic [7:0]  cnt         = 8'h00;
    logic [7:0]  rdata;
    logic        tog;
    logic        irq;
    int          num_errors  = 0;
    int          num_checks  = 0;
    always #4 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) cnt <= cnt + 8'h01;
    tzc_timer u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .addr_in(addr_s),
        .wdata_in(wdata_s), .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata), .ext_pin_in(pin_s),
        .logic_cell_output_in(cnt[0]), .secondary_oscillator_in(cnt[4]),
        .medium_internal_oscillator_in(cnt[3]), .low_freq_oscillator_in(cnt[2]),
        .high_freq_oscillator_in(cnt[1]), .timer_toggle_output_out(tog), .irq_out(irq));
    ////////////////////////////////////////////////////////////////////////////////////
    task end_sim;
        if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk_in); addr_s <= a; wdata_s <= d; wr_s <= 1'b1;
        @(posedge core_clk_in); wr_s <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge core_clk_in); addr_s <= a; rd_s <= 1'b1;
        @(posedge core_clk_in); rd_s <= 1'b0;
        @(negedge core_clk_in); chk({8'h00, rdata}, {8'h00, e});
    endtask
    task nxt(output int k);
        logic t;
        t = tog;
        k = 0;
        while (tog === t && k < 3000) begin @(negedge core_clk_in); k++; end
        if (k >= 3000) begin num_errors++; end_sim(); end
    endtask
    task gap(input logic [15:0] e);
        int k;
        nxt(k); nxt(k); nxt(k);
        chk(16'(k), e);
    endtask
    task pin_step(input logic v, input logic [7:0] e);
        @(posedge core_clk_in); pin_s <= v;
        repeat (12) @(posedge core_clk_in);
        rd(ADDR_COUNT_LOW, e);
    endtask
    ////////////////////////////////////////////////////////////////////////////////////
    int          k;
    logic        t;
    logic [15:0] rate [2:7] = '{16'd4, 16'd4, 16'd8, 16'd16, 16'd32, 16'd2};
    initial begin
        repeat (4) @(posedge core_clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 4; i++) rd(ADDR_COUNT_LOW + 12'(i), RESET_BYTE);
        rd(12'h5A2, 8'h00);
        wr(ADDR_CONTROL_ZERO, 8'h7F); rd(ADDR_CONTROL_ZERO, 8'h1F);
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_CONTROL_ONE, {3'(i), 5'h15}); rd(ADDR_CONTROL_ONE, {3'(i), 5'h15});
        end
        wr(ADDR_COUNT_HIGH, 8'h03);
        wr(ADDR_CONTROL_ONE, 8'h40); wr(ADDR_CONTROL_ZERO, 8'h80); gap(16'd16);
        wr(ADDR_CONTROL_ZERO, 8'h82); gap(16'd48);
        wr(ADDR_CONTROL_ZERO, 8'h8F); gap(16'd256);
        wr(ADDR_CONTROL_ZERO, 8'h80); wr(ADDR_CONTROL_ONE, 8'h42); gap(16'd64);
        for (int c = 2; c < 8; c++) begin
            wr(ADDR_CONTROL_ONE, {3'(c), 5'h10}); gap(rate[c] * 16'd4);
        end
        wr(ADDR_CONTROL_ONE, 8'hE0); gap(16'd16);
        wr(ADDR_CONTROL_ZERO, 8'h00); t = tog;
        repeat (200) @(negedge core_clk_in);
        chk({15'h0, tog}, {15'h0, t});
        wr(ADDR_CONTROL_ONE, 8'h10); wr(ADDR_CONTROL_ZERO, 8'h10);
        wr(ADDR_COUNT_HIGH, 8'h12); wr(ADDR_COUNT_LOW, 8'h34);
        rd(ADDR_COUNT_LOW, 8'h34); rd(ADDR_COUNT_HIGH, 8'h12);
        wr(ADDR_COUNT_HIGH, 8'h00); wr(ADDR_COUNT_LOW, 8'h00); wr(ADDR_CONTROL_ZERO, 8'h90);
        pin_step(1'b1, 8'h01); wr(ADDR_CONTROL_ONE, 8'h30); pin_step(1'b0, 8'h02);
        wr(ADDR_CONTROL_ONE, 8'h10); pin_step(1'b1, 8'h03); pin_step(1'b0, 8'h03);
        wr(ADDR_CONTROL_ZERO, 8'h10); wr(ADDR_COUNT_HIGH, 8'hFF); wr(ADDR_COUNT_LOW, 8'hF0);
        wr(ADDR_CONTROL_ONE, 8'h40); wr(ADDR_CONTROL_ZERO, 8'h90); nxt(k);
        chk(16'(k > 60 && k < 80), 16'h0001);
        wr(ADDR_CONTROL_ONE, 8'h42);
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_COUNT_LOW, 8'h00); repeat (6) @(posedge core_clk_in);
        end
        rd(ADDR_COUNT_LOW, 8'h00);
        wr(ADDR_CONTROL_ZERO, 8'h00); wr(ADDR_IRQ_STATUS, 8'h01); wr(ADDR_IRQ_MASK, 8'h01);
        repeat (3) @(negedge core_clk_in);
        chk({15'h0, irq}, 16'h0000);
        wr(ADDR_COUNT_HIGH, 8'h03); wr(ADDR_COUNT_LOW, 8'h00); wr(ADDR_CONTROL_ZERO, 8'h80);
        nxt(k); repeat (3) @(negedge core_clk_in);
        chk({15'h0, irq}, 16'h0001);
        wr(ADDR_CONTROL_ZERO, 8'h00); wr(ADDR_IRQ_MASK, 8'h00); repeat (3) @(negedge core_clk_in);
        chk({15'h0, irq}, 16'h0000);
        rd(ADDR_IRQ_STATUS, 8'h01); wr(ADDR_IRQ_STATUS, 8'h01); rd(ADDR_IRQ_STATUS, 8'h00);
        wr(ADDR_IRQ_MASK, 8'h01); repeat (3) @(negedge core_clk_in);
        chk({15'h0, irq}, 16'h0000);
        end_sim();
    end
endmodule
